/* File: hdl/core_timing_pkg.sv */
// Constants for the core memory timing and read-sense block.
// Assumes a single 100 MHz clock; times below are given in ns and rounded up to whole clock cycles.
package core_timing_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int DELAY_NS = 15000;
	localparam int DELAY_CYC = (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAP_STEP_NS = 500;
	localparam int TAP_STEP_CYC = (TAP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRETCH_NS = 1000;
	localparam int STRETCH_CYC = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int NUM_TAPS = 30;
	localparam int NUM_USED = 8;
	localparam int WORD_W = 6;
	localparam int DELAY_CNT_W = 11;
	localparam int STEP_CNT_W = 6;
	localparam int TAP_IDX_W = 5;
	localparam int STRETCH_CNT_W = 7;

	// ------------------------------------------------------------
	// Taps that steer the memory cycle
	// ------------------------------------------------------------
	localparam logic [TAP_IDX_W-1:0] TAP_READ_ON = 5'h01;
	localparam logic [TAP_IDX_W-1:0] TAP_STROBE_ON = 5'h03;
	localparam logic [TAP_IDX_W-1:0] TAP_READ_OFF = 5'h05;
	localparam logic [TAP_IDX_W-1:0] TAP_STROBE_OFF = 5'h05;
	localparam logic [TAP_IDX_W-1:0] TAP_INH_ON = 5'h06;
	localparam logic [TAP_IDX_W-1:0] TAP_WRITE_ON = 5'h07;
	localparam logic [TAP_IDX_W-1:0] TAP_WRITE_OFF = 5'h0B;
	localparam logic [TAP_IDX_W-1:0] TAP_INH_OFF = 5'h0C;
	localparam logic [NUM_USED-1:0][TAP_IDX_W-1:0] USED_TAPS = {
		5'h0C, 5'h0B, 5'h07, 5'h06, 5'h05, 5'h03, 5'h01, 5'h00};

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [WORD_W-1:0] WORD_RESET = 6'h00;
	localparam logic [NUM_TAPS-1:0] TAPS_RESET = 30'h0000_0000;

	typedef enum logic [1:0] {
		CHAIN_IDLE,
		CHAIN_RUN,
		CHAIN_HOLD
	} chain_state_e;

endpackage

/* File: hdl/sense_gate.sv */
// One bit of the read sense gate with its output stretcher.
// Sense inputs come from the core plane and are synchronised here;
// strobe and enable come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module sense_gate (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Sense line, either polarity
	input wire logic sense_pos_i,
	input wire logic sense_neg_i,
	// Gating
	input wire logic strobe_i,
	input wire logic enable_i,
	// Stretched result
	output logic bit_o
);

	logic [1:0] pos_sync_q, pos_sync_d;
	logic [1:0] neg_sync_q, neg_sync_d;
	logic [core_timing_pkg::STRETCH_CNT_W-1:0] cnt_q, cnt_d;
	logic bit_q, bit_d;
	logic hit;

	// ------------------------------------------------------------
	// Coincidence and stretch
	// ------------------------------------------------------------
	always_comb begin
		pos_sync_d = {pos_sync_q[0], sense_pos_i};
		neg_sync_d = {neg_sync_q[0], sense_neg_i};
		hit = (pos_sync_q[1] | neg_sync_q[1]) & strobe_i & enable_i;
		cnt_d = cnt_q;
		if (hit) begin
			cnt_d = core_timing_pkg::STRETCH_CNT_W'(core_timing_pkg::STRETCH_CYC);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
		bit_d = (cnt_d != '0);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pos_sync_q <= 2'h0;
			neg_sync_q <= 2'h0;
			cnt_q <= '0;
			bit_q <= 1'b0;
		end else begin
			pos_sync_q <= pos_sync_d;
			neg_sync_q <= neg_sync_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
		end
	end

	assign bit_o = bit_q;

endmodule // sense_gate

`default_nettype wire

/* File: hdl/core_memory_timing_sense.sv */
// Timing and read-sense logic of a small core memory section:
// a fixed pulse delay, a tapped timing chain and a per-bit sense gate.
// Pins from the core planes and the trigger pins are asynchronous;
// the store-new-word request comes from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module core_memory_timing_sense (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Pulse delay element, active low
	input wire logic delay_in_n_i,
	output logic delay_out_n_o,
	// Timing chain
	input wire logic op_start_i,
	output logic [core_timing_pkg::NUM_TAPS-1:0] tap_o,
	output logic [core_timing_pkg::NUM_USED-1:0] timing_o,
	// Read/write control
	input wire logic load_new_i,
	input wire logic [core_timing_pkg::WORD_W-1:0] new_word_i,
	// Core plane drive and sense
	input wire logic [core_timing_pkg::WORD_W-1:0] sense_pos_i,
	input wire logic [core_timing_pkg::WORD_W-1:0] sense_neg_i,
	output logic read_drive_o,
	output logic write_drive_o,
	output logic [core_timing_pkg::WORD_W-1:0] inhibit_o,
	// Sense gating and data buffer
	output logic strobe_o,
	output logic enable_o,
	output logic [core_timing_pkg::WORD_W-1:0] sense_bit_o,
	output logic [core_timing_pkg::WORD_W-1:0] data_word_o
);

	localparam int W = core_timing_pkg::WORD_W;
	localparam int NT = core_timing_pkg::NUM_TAPS;

	// ------------------------------------------------------------
	// Pulse delay element
	// ------------------------------------------------------------
	logic [1:0] din_sync_q, din_sync_d;
	logic din_prev_q, din_prev_d;
	logic [core_timing_pkg::DELAY_CNT_W-1:0] dly_cnt_q, dly_cnt_d;
	logic dout_n_q, dout_n_d;

	always_comb begin
		din_sync_d = {din_sync_q[0], delay_in_n_i};
		din_prev_d = din_sync_q[1];
		dly_cnt_d = dly_cnt_q;
		if (!din_sync_q[1]) begin
			// Input held low: output stays idle
			dly_cnt_d = '0;
		end else if (!din_prev_q) begin
			// Trailing edge of the input pulse starts the output
			dly_cnt_d = core_timing_pkg::DELAY_CNT_W'(core_timing_pkg::DELAY_CYC);
		end else if (dly_cnt_q != '0) begin
			dly_cnt_d = dly_cnt_q - 1'b1;
		end
		dout_n_d = (dly_cnt_d == '0);
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			din_sync_q <= 2'h3;
			din_prev_q <= 1'b1;
			dly_cnt_q <= '0;
			dout_n_q <= 1'b1;
		end else begin
			din_sync_q <= din_sync_d;
			din_prev_q <= din_prev_d;
			dly_cnt_q <= dly_cnt_d;
			dout_n_q <= dout_n_d;
		end
	end

	assign delay_out_n_o = dout_n_q;

	// ------------------------------------------------------------
	// Tapped timing chain
	// ------------------------------------------------------------
	logic [1:0] start_sync_q, start_sync_d;
	logic start_prev_q, start_prev_d;
	core_timing_pkg::chain_state_e state_q, state_d;
	logic [core_timing_pkg::STEP_CNT_W-1:0] step_q, step_d;
	logic [core_timing_pkg::TAP_IDX_W-1:0] idx_q, idx_d;
	logic [NT-1:0] tap_q, tap_d;
	logic launch;

	always_comb begin
		start_sync_d = {start_sync_q[0], op_start_i};
		start_prev_d = start_sync_q[1];
		launch = start_sync_q[1] & ~start_prev_q;
		state_d = state_q;
		step_d = step_q;
		idx_d = idx_q;
		tap_d = tap_q;
		unique case (state_q)
			core_timing_pkg::CHAIN_IDLE: begin
				if (launch) begin
					tap_d = core_timing_pkg::TAPS_RESET;
					tap_d[0] = 1'b1;
					step_d = '0;
					idx_d = core_timing_pkg::TAP_IDX_W'(1);
					state_d = core_timing_pkg::CHAIN_RUN;
				end else if (!start_sync_q[1]) begin
					tap_d = core_timing_pkg::TAPS_RESET;
				end
			end
			core_timing_pkg::CHAIN_RUN: begin
				// Runs to the last tap even if the trigger drops early
				if (step_q == core_timing_pkg::STEP_CNT_W'(core_timing_pkg::TAP_STEP_CYC - 1)) begin
					step_d = '0;
					tap_d[idx_q] = 1'b1;
					idx_d = idx_q + 1'b1;
					if (idx_q == core_timing_pkg::TAP_IDX_W'(NT - 1)) begin
						state_d = core_timing_pkg::CHAIN_HOLD;
					end
				end else begin
					step_d = step_q + 1'b1;
				end
			end
			core_timing_pkg::CHAIN_HOLD: begin
				if (!start_sync_q[1]) begin
					tap_d = core_timing_pkg::TAPS_RESET;
					state_d = core_timing_pkg::CHAIN_IDLE;
				end
			end
			default: begin
				state_d = core_timing_pkg::CHAIN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_sync_q <= 2'h0;
			start_prev_q <= 1'b0;
			state_q <= core_timing_pkg::CHAIN_IDLE;
			step_q <= '0;
			idx_q <= '0;
			tap_q <= core_timing_pkg::TAPS_RESET;
		end else begin
			start_sync_q <= start_sync_d;
			start_prev_q <= start_prev_d;
			state_q <= state_d;
			step_q <= step_d;
			idx_q <= idx_d;
			tap_q <= tap_d;
		end
	end

	assign tap_o = tap_q;

	for (genvar k = 0; k < core_timing_pkg::NUM_USED; k++) begin : g_used
		assign timing_o[k] = tap_q[core_timing_pkg::USED_TAPS[k]];
	end

	// ------------------------------------------------------------
	// Memory cycle phases
	// ------------------------------------------------------------
	logic read_q, read_d;
	logic write_q, write_d;
	logic strobe_q, strobe_d;
	logic enable_q, enable_d;
	logic [W-1:0] inhibit_q, inhibit_d;
	logic inh_window;
	logic [W-1:0] data_q, data_d;

	always_comb begin
		read_d = tap_q[core_timing_pkg::TAP_READ_ON] & ~tap_q[core_timing_pkg::TAP_READ_OFF];
		write_d = tap_q[core_timing_pkg::TAP_WRITE_ON] & ~tap_q[core_timing_pkg::TAP_WRITE_OFF];
		// Strobe closes before the rewrite starts
		strobe_d = tap_q[core_timing_pkg::TAP_STROBE_ON]
			& ~tap_q[core_timing_pkg::TAP_STROBE_OFF];
		enable_d = ~load_new_i;
		inh_window = tap_q[core_timing_pkg::TAP_INH_ON] & ~tap_q[core_timing_pkg::TAP_INH_OFF];
		inhibit_d = {W{inh_window}} & ~data_q;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			read_q <= 1'b0;
			write_q <= 1'b0;
			strobe_q <= 1'b0;
			enable_q <= 1'b0;
			inhibit_q <= core_timing_pkg::WORD_RESET;
		end else begin
			read_q <= read_d;
			write_q <= write_d;
			strobe_q <= strobe_d;
			enable_q <= enable_d;
			inhibit_q <= inhibit_d;
		end
	end

	assign read_drive_o = read_q;
	assign write_drive_o = write_q;
	assign strobe_o = strobe_q;
	assign enable_o = enable_q;
	assign inhibit_o = inhibit_q;

	// ------------------------------------------------------------
	// Sense gates and data buffer
	// ------------------------------------------------------------
	logic [W-1:0] sense_bit;

	for (genvar b = 0; b < W; b++) begin : g_sense
		sense_gate u_sense (
			.clk_i(clk_i),
			.resetn_i(resetn_i),
			.sense_pos_i(sense_pos_i[b]),
			.sense_neg_i(sense_neg_i[b]),
			.strobe_i(strobe_q),
			.enable_i(enable_q),
			.bit_o(sense_bit[b])
		);
	end

	always_comb begin
		data_d = data_q | sense_bit;
		if (state_q == core_timing_pkg::CHAIN_IDLE && launch) begin
			// Buffer is cleared before the read, or loaded with the word to store
			data_d = load_new_i ? new_word_i : core_timing_pkg::WORD_RESET;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_q <= core_timing_pkg::WORD_RESET;
		end else begin
			data_q <= data_d;
		end
	end

	assign sense_bit_o = sense_bit;
	assign data_word_o = data_q;

endmodule // core_memory_timing_sense

`default_nettype wire

/* File: tb/core_chk.sv */
// Port checker for the core timing and sense block.
// Assumes one clock domain and the active-low reset of the block.
`timescale 1ns/10ps
`default_nettype none
module core_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Watched ports
	input wire logic delay_in_n_i,
	input wire logic delay_out_n_o,
	input wire logic load_new_i,
	input wire logic [29:0] tap_o,
	input wire logic [7:0] timing_o,
	input wire logic read_drive_o,
	input wire logic write_drive_o,
	input wire logic strobe_o,
	input wire logic enable_o,
	input wire logic [5:0] inhibit_o,
	input wire logic [5:0] sense_bit_o,
	input wire logic [5:0] data_word_o
);
	// ----
	// Low-time counter of the delay output
	// ----
	logic [10:0] lo_q;
	logic [10:0] lo_d;
	always_comb begin
		lo_d = delay_out_n_o ? 11'h000 : lo_q + 11'h001;
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) lo_q <= 11'h000;
		else lo_q <= lo_d;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_delay_hold: assert property ((!delay_in_n_i)[*4] |-> delay_out_n_o)
		else $error("delay output active while input low");
	a_delay_start: assert property ($rose(delay_in_n_i) |-> ##[2:4] !delay_out_n_o)
		else $error("delay output late after input end");
	a_delay_width: assert property ($rose(delay_out_n_o) && delay_in_n_i |-> lo_q == 11'h5DC)
		else $error("delay output width wrong");
	a_tap_order: assert property ((tap_o[29:1] & ~tap_o[28:0]) == 29'h0)
		else $error("tap set before its predecessor");
	a_tap_step: assert property ($rose(tap_o[1]) |->
		$past(tap_o[0], 50) && !$past(tap_o[0], 51))
		else $error("tap spacing wrong");
	a_timing_map: assert property (timing_o == {tap_o[12], tap_o[11], tap_o[7],
		tap_o[6], tap_o[5], tap_o[3], tap_o[1], tap_o[0]})
		else $error("used taps wrong");
	a_strobe_win: assert property (strobe_o == $past(tap_o[3] && !tap_o[5]))
		else $error("strobe window wrong");
	a_read_win: assert property (read_drive_o == $past(tap_o[1] && !tap_o[5]))
		else $error("read window wrong");
	a_write_win: assert property (write_drive_o == $past(tap_o[7] && !tap_o[11]))
		else $error("write window wrong");
	a_delay_cut: assert property ($fell(delay_in_n_i) |-> ##[2:4] delay_out_n_o)
		else $error("delay output not cut by input");
	a_inhibit_win: assert property (inhibit_o ==
		({6{$past(tap_o[6] && !tap_o[12])}} & ~$past(data_word_o)))
		else $error("inhibit wrong");
	a_sense_gate: assert property ((sense_bit_o & ~$past(sense_bit_o)) != 6'h00 |->
		$past(strobe_o && enable_o))
		else $error("sense passed without strobe and enable");
	a_enable_inv: assert property ($past(resetn_i) |-> enable_o == !$past(load_new_i))
		else $error("enable not from control state");
	c_delay: cover property ($fell(delay_out_n_o));
	c_chain: cover property ($rose(tap_o[29]));
	c_sense: cover property ($rose(sense_bit_o[0]));
endmodule // core_chk
bind core_memory_timing_sense core_chk u_chk (.clk_i, .resetn_i, .delay_in_n_i,
	.delay_out_n_o, .load_new_i, .tap_o, .timing_o, .read_drive_o, .write_drive_o, .strobe_o,
	.enable_o, .inhibit_o, .sense_bit_o, .data_word_o);
`default_nettype wire

/* File: tb/core_planes.sv */
// Behavioural model of the core planes and their sense windings.
// Driven by the block's drive, strobe and inhibit outputs.
`timescale 1ns/10ps
`default_nettype none
module core_planes #(
	parameter logic [5:0] INIT = 6'h35
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Drives
	input wire logic read_drive_i,
	input wire logic write_drive_i,
	input wire logic strobe_i,
	input wire logic [5:0] inhibit_i,
	// Sense lines and contents
	output logic [5:0] sense_pos_o,
	output logic [5:0] sense_neg_o,
	output logic [5:0] mem_o
);
	// Odd planes answer a one with reversed current
	localparam logic [5:0] POL = 6'h2A;
	logic [5:0] hit_q;
	logic [2:0] len_q;
	logic st_q;
	logic wr_q;
	logic neg_q;
	logic [5:0] act;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mem_o <= INIT;
			hit_q <= 6'h00;
			len_q <= 3'h0;
			neg_q <= 1'b0;
			st_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			if (read_drive_i && strobe_i && !st_q) begin
				hit_q <= mem_o;
				mem_o <= 6'h00;
				len_q <= 3'h4;
				neg_q <= 1'b0;
			end else if (write_drive_i && !wr_q) begin
				hit_q <= ~inhibit_i;
				mem_o <= ~inhibit_i;
				len_q <= 3'h4;
				neg_q <= 1'b1;
			end else if (len_q != 3'h0) begin
				len_q <= len_q - 3'h1;
			end
			st_q <= strobe_i;
			wr_q <= write_drive_i;
		end
	end
	assign act = (len_q != 3'h0) ? hit_q : 6'h00;
	assign sense_pos_o = act & (neg_q ? POL : ~POL);
	assign sense_neg_o = act & (neg_q ? ~POL : POL);
endmodule // core_planes
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the core timing and sense block.
// Assumes the plane model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_i, resetn_i, delay_in_n_i, delay_out_n_o, op_start_i, load_new_i;
	logic read_drive_o, write_drive_o, strobe_o, enable_o;
	logic [5:0] new_word_i, sense_pos, sense_neg, inhibit_o, sense_bit_o, data_word_o, mem;
	logic [29:0] tap_o;
	logic [7:0] timing_o;
	int err_count, n_checks, span, hi;
	core_memory_timing_sense u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.delay_in_n_i(delay_in_n_i), .delay_out_n_o(delay_out_n_o),
		.op_start_i(op_start_i), .tap_o(tap_o), .timing_o(timing_o),
		.load_new_i(load_new_i), .new_word_i(new_word_i), .sense_pos_i(sense_pos),
		.sense_neg_i(sense_neg), .read_drive_o(read_drive_o), .write_drive_o(write_drive_o),
		.inhibit_o(inhibit_o), .strobe_o(strobe_o), .enable_o(enable_o),
		.sense_bit_o(sense_bit_o), .data_word_o(data_word_o));
	core_planes u_mem (.clk_i(clk_i), .resetn_i(resetn_i), .read_drive_i(read_drive_o),
		.write_drive_i(write_drive_o), .strobe_i(strobe_o), .inhibit_i(inhibit_o),
		.sense_pos_o(sense_pos), .sense_neg_o(sense_neg), .mem_o(mem));
	// ----
	// Shared tasks
	// ----
	task tick;
		@(posedge clk_i);
		#1;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (exp !== got) begin
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
			err_count++;
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task run_cycle(input logic ld, input logic [5:0] w);
		int k;
		@(posedge clk_i);
		load_new_i <= ld;
		new_word_i <= w;
		op_start_i <= 1'b1;
		k = 0;
		while (tap_o[0] !== 1'b1 && k < 10) begin
			tick;
			k++;
		end
		span = 0;
		hi = 0;
		while (tap_o[29] !== 1'b1 && span < 2000) begin
			tick;
			span++;
			if (sense_bit_o[0] === 1'b1) hi++;
		end
		chk("all taps", 30'h3FFFFFFF, tap_o);
		@(posedge clk_i);
		op_start_i <= 1'b0;
		load_new_i <= 1'b0;
		repeat (5) tick;
		chk("idle taps", 30'h0, tap_o);
	endtask
	// ----
	// Scenarios
	// ----
	task t_delay;
		int k;
		@(posedge clk_i);
		delay_in_n_i <= 1'b0;
		repeat (1500) tick;
		chk("delay held", 1'b1, delay_out_n_o);
		@(posedge clk_i);
		delay_in_n_i <= 1'b1;
		k = 0;
		while (delay_out_n_o !== 1'b0 && k < 10) begin
			tick;
			k++;
		end
		chk("delay start", 3, k);
		k = 0;
		while (delay_out_n_o === 1'b0 && k < 2000) begin
			tick;
			k++;
		end
		chk("delay width", 1500, k);
		// Short pulse, then cut the output by asserting the input again
		@(posedge clk_i);
		delay_in_n_i <= 1'b0;
		repeat (20) tick;
		@(posedge clk_i);
		delay_in_n_i <= 1'b1;
		repeat (103) tick;
		chk("delay restart", 1'b0, delay_out_n_o);
		@(posedge clk_i);
		delay_in_n_i <= 1'b0;
		repeat (4) tick;
		chk("delay cut", 1'b1, delay_out_n_o);
		@(posedge clk_i);
		delay_in_n_i <= 1'b1;
		$display("test delay done");
	endtask
	task t_read;
		run_cycle(1'b0, 6'h00);
		chk("tap span", 1450, span);
		chk("read word", 6'h35, data_word_o);
		chk("restored", 6'h35, mem);
		chk("stretch", 1'b1, hi >= 100);
		$display("test read done");
	endtask
	task t_store;
		run_cycle(1'b1, 6'h0A);
		chk("stored buffer", 6'h0A, data_word_o);
		chk("stored core", 6'h0A, mem);
		run_cycle(1'b0, 6'h00);
		chk("reread", 6'h0A, data_word_o);
		chk("enable idle", 1'b1, enable_o);
		$display("test store done");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		err_count++;
		conclude;
	end
	initial begin
		resetn_i = 1'b0;
		delay_in_n_i = 1'b1;
		op_start_i = 1'b0;
		load_new_i = 1'b0;
		new_word_i = 6'h00;
		err_count = 0;
		n_checks = 0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (3) tick;
		t_delay;
		t_read;
		t_store;
		conclude;
	end
endmodule // tb
`default_nettype wire
